//--- core/cycle_timer.sv
`timescale 1ns/1ps
`default_nettype none

module cycle_timer #(
	parameter int TW = 16
) (
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic          load,
	input  wire logic [TW-1:0] load_value,
	input  wire logic          run,
	input  wire logic          stop,
	output logic               expired
);

	logic [TW-1:0] count_reg;
	logic          armed_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_reg <= '0;
			armed_reg <= 1'b0;
		end else if (load) begin
			count_reg <= load_value;
			armed_reg <= 1'b1;
		end else if (stop) begin
			armed_reg <= 1'b0;
		end else if (run && armed_reg && count_reg != '0) begin
			count_reg <= count_reg - TW'(1);
		end
	end

	// level until reload or stop
	assign expired = armed_reg && (count_reg == '0);

endmodule : cycle_timer

`default_nettype wire

//--- core/flash_erase_sequencer.sv
// Function
// R1 - Whole-array erase is six writes, each byte decoded in turn.
// R2 - A wrong whole-array erase byte returns to read mode.
// R3 - Error bit set when erase iterations reach the maximum.
// R4 - Erase status reads give error, toggle and polling bits.
// R5 - Bytes are programmed to zeros, then erased to ones.
// R6 - While whole-array erase runs, every further command is ignored; the code accepts reset once the error bit is set.
// R7 - Sector erase is six writes; final select picks the sector.
// R8 - Sector codes within the window add sectors.
// R9 - Each extra sector code restarts the window.
// R10 - Window bit low while window counts, high once erasing.
// R11 - In the window, other than suspend or resume aborts.
// R12 - Sector erase accepts only reset and suspend; the code ignores suspend once the error bit is set.
// R13 - Suspend keeps erase state; resume continues.
// R14 - Suspend is one B0 hex write with a sector select high.
// R15 - Commands open with AA at 555, 55 at AAA.
// R16 - Main selects route to main flash, boot selects to boot flash.
// R17 - Bad byte or long gap returns decoder to read mode.
// R18 - Later command bytes and resume code are parameters.
// R19 - Window is a cycle counter with parameter terminal count.
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "flash_erase_regs.svh"

module flash_erase_sequencer #(
	parameter int         MAIN_N      = 8,
	parameter int         BOOT_N      = 4,
	parameter int         TW          = 16,
	parameter logic [7:0] SETUP_CODE  = `ERASE_SETUP_DATA,
	parameter logic [7:0] CHIP_CODE   = `CHIP_ERASE_DATA,
	parameter logic [7:0] SECTOR_CODE = `SECTOR_ERASE_DATA,
	parameter logic [7:0] RESUME_CODE = `RESUME_DATA,
	parameter logic [7:0] RESET_CODE  = `RESET_DATA,
	parameter int         WINDOW_CYC  = `WINDOW_CYCLES,
	parameter int         GAP_CYC     = `GAP_CYCLES,
	parameter int         PROG_CYC    = `PROG_CYCLES,
	parameter int         PULSE_CYC   = `PULSE_CYCLES,
	parameter int         MAX_ITER    = `MAX_ERASE_ITER,
	localparam int        NS          = MAIN_N + BOOT_N,
	localparam int        SW          = $clog2(NS),
	localparam int        IW          = $clog2(MAX_ITER + 1)
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic [11:0]       mem_addr,
	input  wire logic [7:0]        mem_wdata,
	input  wire logic              mem_wr,
	input  wire logic              mem_rd,
	input  wire logic [MAIN_N-1:0] main_sector_selects,
	input  wire logic [BOOT_N-1:0] boot_sector_selects,
	output logic [7:0]             mem_rdata,
	output logic                   mem_rdata_valid,
	output logic [SW-1:0]          array_sector,
	output logic                   array_program,
	output logic                   array_erase,
	output logic [7:0]             array_fill,
	input  wire logic              array_verify_ok,
	input  wire logic [7:0]        array_rdata,
	output logic                   erase_busy,
	output logic                   irq
);

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic is_cmd(input logic [11:0] a, input logic [7:0] d,
		input logic [11:0] ea, input logic [7:0] ed);
		is_cmd = (a == ea) && (d == ed);
	endfunction : is_cmd

	function automatic logic [SW-1:0] lowest_index(input logic [NS-1:0] m);
		lowest_index = '0;
		for (int i = NS - 1; i >= 0; i--) begin
			if (m[i])
				lowest_index = SW'(i);
		end
	endfunction : lowest_index

	function automatic logic reg_known(input logic [7:0] a);
		reg_known = (a == `CTRL_OFFSET) || (a == `STATUS_OFFSET) || (a == `IRQ_STATUS_OFFSET) ||
			(a == `IRQ_MASK_OFFSET) || (a == `PENDING_OFFSET);
	endfunction : reg_known

	localparam logic [NS-1:0] MAIN_MASK = {{BOOT_N{1'b0}}, {MAIN_N{1'b1}}};
	localparam logic [NS-1:0] BOOT_MASK = {{BOOT_N{1'b1}}, {MAIN_N{1'b0}}};

	erase_pkg::state_t state_reg, state_next;
	logic [NS-1:0]      pending_reg;
	logic               target_boot_reg;
	logic               err_reg;
	logic               prog_phase_reg;
	logic               pulse_active_reg;
	logic [IW-1:0]      iter_reg;
	logic               toggle_reg;
	logic               ctrl_enable_reg;
	logic [2:0]         irq_mask_reg;
	logic [2:0]         irq_stat_reg;
	logic               bvalid_reg;
	logic               rvalid_reg;

	logic               sel_any, wr_ok, gap_exp, win_exp, pulse_exp;
	logic               c_unl1, c_unl2, c_setup, c_chip, c_sector, c_suspend, c_resume, c_reset;
	logic               load_win, add_sect, enter_bulk, abort_ev;
	logic [NS-1:0]      hit_sect, target_mask, cur_bit;
	logic               erasing, eng_run, step, eng_done, err_set;
	logic               in_cmd_entry;
	logic [7:0]         status_byte;
	logic               do_wr, do_rd;
	logic [2:0]         events;

	// ************************************************************
	// command decode
	// ************************************************************
	assign sel_any     = (|main_sector_selects) || (|boot_sector_selects);
	assign wr_ok       = mem_wr && sel_any && ctrl_enable_reg;
	assign hit_sect    = {boot_sector_selects, main_sector_selects};
	assign target_mask = target_boot_reg ? BOOT_MASK : MAIN_MASK; // [R16]
	assign c_unl1      = is_cmd(mem_addr, mem_wdata, `UNLOCK1_ADDR, `UNLOCK1_DATA); // [R15]
	assign c_unl2      = is_cmd(mem_addr, mem_wdata, `UNLOCK2_ADDR, `UNLOCK2_DATA); // [R15]
	assign c_setup     = is_cmd(mem_addr, mem_wdata, `UNLOCK1_ADDR, SETUP_CODE); // [R18]
	assign c_chip      = is_cmd(mem_addr, mem_wdata, `UNLOCK1_ADDR, CHIP_CODE); // [R18]
	assign c_sector    = mem_wdata == SECTOR_CODE;
	assign c_suspend   = mem_wdata == `SUSPEND_DATA; // [R14]
	assign c_resume    = mem_wdata == RESUME_CODE;
	assign c_reset     = mem_wdata == RESET_CODE;

	assign in_cmd_entry = state_reg inside {erase_pkg::ST_UNL1, erase_pkg::ST_UNL2, erase_pkg::ST_SETUP,
		erase_pkg::ST_SU1, erase_pkg::ST_SU2};
	assign erasing = (state_reg == erase_pkg::ST_BULK) || (state_reg == erase_pkg::ST_SECTOR);

	always_comb begin
		state_next = state_reg;
		load_win   = 1'b0;
		add_sect   = 1'b0;
		enter_bulk = 1'b0;
		case (state_reg)
			erase_pkg::ST_READ: begin
				if (wr_ok && c_unl1)
					state_next = erase_pkg::ST_UNL1; // [R15]
			end
			erase_pkg::ST_UNL1, erase_pkg::ST_SETUP, erase_pkg::ST_SU1, erase_pkg::ST_UNL2: begin
				if (gap_exp)
					state_next = erase_pkg::ST_READ; // [R17]
				else if (wr_ok) begin
					state_next = erase_pkg::ST_READ; // [R2] [R17]
					if (state_reg == erase_pkg::ST_UNL1 && c_unl2)
						state_next = erase_pkg::ST_UNL2;
					if (state_reg == erase_pkg::ST_UNL2 && c_setup)
						state_next = erase_pkg::ST_SETUP;
					if (state_reg == erase_pkg::ST_SETUP && c_unl1)
						state_next = erase_pkg::ST_SU1;
					if (state_reg == erase_pkg::ST_SU1 && c_unl2)
						state_next = erase_pkg::ST_SU2; // [R1]
				end
			end
			erase_pkg::ST_SU2: begin
				if (gap_exp)
					state_next = erase_pkg::ST_READ; // [R17]
				else if (wr_ok) begin
					if (c_chip) begin
						state_next = erase_pkg::ST_BULK; // [R1]
						enter_bulk = 1'b1;
					end else if (c_sector) begin
						state_next = erase_pkg::ST_COLLECT; // [R7]
						add_sect   = 1'b1;
						load_win   = 1'b1;
					end else
						state_next = erase_pkg::ST_READ; // [R2]
				end
			end
			erase_pkg::ST_COLLECT: begin
				if (wr_ok && c_sector) begin
					add_sect = 1'b1; // [R8]
					load_win = 1'b1; // [R9]
				end else if (wr_ok && !c_suspend && !c_resume)
					state_next = erase_pkg::ST_READ; // [R11]
				else if (win_exp)
					state_next = erase_pkg::ST_SECTOR; // [R19]
			end
			erase_pkg::ST_BULK: begin
				if (eng_done)
					state_next = erase_pkg::ST_READ;
				else if (wr_ok && err_reg && c_reset)
					state_next = erase_pkg::ST_READ; // [R6]
			end
			erase_pkg::ST_SECTOR: begin
				if (eng_done)
					state_next = erase_pkg::ST_READ;
				else if (wr_ok && c_reset)
					state_next = erase_pkg::ST_READ; // [R12]
				else if (wr_ok && c_suspend && !err_reg)
					state_next = erase_pkg::ST_SUSPEND; // [R12] [R14]
			end
			erase_pkg::ST_SUSPEND: begin
				if (wr_ok && c_resume)
					state_next = erase_pkg::ST_SECTOR; // [R13]
				else if (wr_ok && c_reset)
					state_next = erase_pkg::ST_READ;
			end
			default: state_next = erase_pkg::ST_READ;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			state_reg <= erase_pkg::ST_READ;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			target_boot_reg <= 1'b0;
		else if (state_reg == erase_pkg::ST_READ && wr_ok && c_unl1)
			target_boot_reg <= ~(|main_sector_selects); // [R16]
	end

	// ************************************************************
	// timers
	// ************************************************************
	cycle_timer #(.TW(TW)) gap_timer (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.load       (wr_ok),
		.load_value (TW'(GAP_CYC)),
		.run        (in_cmd_entry),
		.stop       (!in_cmd_entry),
		.expired    (gap_exp)
	); // [R17]

	cycle_timer #(.TW(TW)) window_timer (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.load       (load_win),
		.load_value (TW'(WINDOW_CYC)),
		.run        (state_reg == erase_pkg::ST_COLLECT),
		.stop       (state_reg != erase_pkg::ST_COLLECT),
		.expired    (win_exp)
	); // [R9] [R19]

	cycle_timer #(.TW(TW)) pulse_timer (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.load       (eng_run && !pulse_active_reg),
		.load_value (prog_phase_reg ? TW'(PROG_CYC) : TW'(PULSE_CYC)),
		.run        (eng_run),
		.stop       (!erasing && state_reg != erase_pkg::ST_SUSPEND),
		.expired    (pulse_exp)
	);

	// ************************************************************
	// erase engine
	// ************************************************************
	assign array_sector = lowest_index(pending_reg);
	assign cur_bit      = NS'(1) << array_sector;
	assign eng_run      = erasing && !err_reg && (|pending_reg);
	assign step         = eng_run && pulse_active_reg && pulse_exp;
	assign eng_done     = step && !prog_phase_reg && array_verify_ok && (pending_reg == cur_bit);
	assign err_set      = step && !prog_phase_reg && !array_verify_ok && (iter_reg == IW'(MAX_ITER - 1));

	always_ff @(posedge aclk) begin
		if (!aresetn)
			pending_reg <= '0;
		else if (state_next == erase_pkg::ST_READ)
			pending_reg <= '0;
		else if (enter_bulk)
			pending_reg <= target_mask;
		else if (add_sect)
			pending_reg <= pending_reg | (hit_sect & target_mask); // [R7] [R8]
		else if (step && !prog_phase_reg && array_verify_ok)
			pending_reg <= pending_reg & ~cur_bit;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prog_phase_reg   <= 1'b1;
			pulse_active_reg <= 1'b0;
			iter_reg         <= '0;
		end else if (state_next == erase_pkg::ST_READ) begin
			prog_phase_reg   <= 1'b1;
			pulse_active_reg <= 1'b0;
			iter_reg         <= '0;
		end else if (eng_run && !pulse_active_reg) begin
			pulse_active_reg <= 1'b1;
		end else if (step) begin
			pulse_active_reg <= 1'b0;
			if (prog_phase_reg)
				prog_phase_reg <= 1'b0; // [R5]
			else if (array_verify_ok) begin
				prog_phase_reg <= 1'b1;
				iter_reg       <= '0;
			end else if (!err_set)
				iter_reg <= iter_reg + IW'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			err_reg <= 1'b0;
		else if (state_next == erase_pkg::ST_READ)
			err_reg <= 1'b0;
		else if (err_set)
			err_reg <= 1'b1; // [R3]
	end

	assign array_program = eng_run && pulse_active_reg && prog_phase_reg; // [R5]
	assign array_erase   = eng_run && pulse_active_reg && !prog_phase_reg;
	assign array_fill    = prog_phase_reg ? `PREPROGRAM_FILL : `ERASED_FILL; // [R5]
	assign erase_busy    = state_reg != erase_pkg::ST_READ && !in_cmd_entry;

	// ************************************************************
	// status reads
	// ************************************************************
	always_comb begin
		status_byte                = 8'h00;
		status_byte[`POLL_BIT]     = 1'b0;
		status_byte[`TOGGLE_BIT]   = toggle_reg; // [R4]
		status_byte[`ERROR_BIT]    = err_reg; // [R3] [R4]
		status_byte[`WINDOW_BIT]   = state_reg != erase_pkg::ST_COLLECT; // [R10]
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mem_rdata       <= 8'h00;
			mem_rdata_valid <= 1'b0;
			toggle_reg      <= 1'b0;
		end else begin
			mem_rdata_valid <= mem_rd && sel_any;
			if (mem_rd && sel_any) begin
				if (erasing || state_reg == erase_pkg::ST_COLLECT ||
					(state_reg == erase_pkg::ST_SUSPEND && (|(hit_sect & pending_reg)))) begin
					mem_rdata  <= status_byte; // [R4]
					toggle_reg <= ~toggle_reg;
				end else
					mem_rdata <= array_rdata; // [R13]
			end
		end
	end

	// ************************************************************
	// register bus
	// ************************************************************
	assign do_wr         = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
	assign s_axi_awready = do_wr;
	assign s_axi_wready  = do_wr;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign do_rd         = s_axi_arvalid && !rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg  <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else if (do_wr) begin
			bvalid_reg  <= 1'b1;
			s_axi_bresp <= reg_known(s_axi_awaddr) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_bready)
			bvalid_reg <= 1'b0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_enable_reg <= `CTRL_RESET;
			irq_mask_reg    <= 3'h0;
		end else if (do_wr && s_axi_wstrb[0]) begin
			if (s_axi_awaddr == `CTRL_OFFSET)
				ctrl_enable_reg <= s_axi_wdata[`CTRL_ENABLE_BIT];
			if (s_axi_awaddr == `IRQ_MASK_OFFSET)
				irq_mask_reg <= s_axi_wdata[2:0];
		end
	end

	assign abort_ev = (state_next == erase_pkg::ST_READ) && (state_reg != erase_pkg::ST_READ) && !eng_done;
	assign events   = {abort_ev, err_set, eng_done};

	// set wins over clear
	generate
		for (genvar i = 0; i < `IRQ_COUNT; i++) begin : g_irq
			always_ff @(posedge aclk) begin
				if (!aresetn)
					irq_stat_reg[i] <= 1'b0;
				else if (events[i])
					irq_stat_reg[i] <= 1'b1;
				else if (do_wr && s_axi_wstrb[0] && s_axi_awaddr == `IRQ_STATUS_OFFSET && s_axi_wdata[i])
					irq_stat_reg[i] <= 1'b0;
			end
		end
	endgenerate

	assign irq = |(irq_stat_reg & irq_mask_reg);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg  <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (do_rd) begin
			rvalid_reg  <= 1'b1;
			s_axi_rresp <= reg_known(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
			s_axi_rdata <= 32'h0000_0000;
			case (s_axi_araddr)
				`CTRL_OFFSET:       s_axi_rdata[`CTRL_ENABLE_BIT] <= ctrl_enable_reg;
				`STATUS_OFFSET: begin
					s_axi_rdata[9:0]              <= state_reg;
					s_axi_rdata[`ERR_STATUS_BIT]  <= err_reg;
					s_axi_rdata[`BUSY_STATUS_BIT] <= erase_busy;
				end
				`IRQ_STATUS_OFFSET: s_axi_rdata[2:0] <= irq_stat_reg;
				`IRQ_MASK_OFFSET:   s_axi_rdata[2:0] <= irq_mask_reg;
				`PENDING_OFFSET:    s_axi_rdata[NS-1:0] <= pending_reg;
				default:            s_axi_rdata <= 32'h0000_0000;
			endcase
		end else if (s_axi_rready)
			rvalid_reg <= 1'b0;
	end

endmodule : flash_erase_sequencer

`default_nettype wire

//--- include/erase_pkg.sv
package erase_pkg;

	typedef enum logic [9:0] {
		ST_READ    = 10'h001,
		ST_UNL1    = 10'h002,
		ST_UNL2    = 10'h004,
		ST_SETUP   = 10'h008,
		ST_SU1     = 10'h010,
		ST_SU2     = 10'h020,
		ST_COLLECT = 10'h040,
		ST_BULK    = 10'h080,
		ST_SECTOR  = 10'h100,
		ST_SUSPEND = 10'h200
	} state_t;

endpackage : erase_pkg

//--- include/flash_erase_regs.svh
`ifndef FLASH_ERASE_REGS_SVH
`define FLASH_ERASE_REGS_SVH

// ************************************************************
// command bytes and addresses (low 12 address bits only)
// ************************************************************
`define UNLOCK1_ADDR      12'h555
`define UNLOCK2_ADDR      12'hAAA
`define UNLOCK1_DATA      8'hAA
`define UNLOCK2_DATA      8'h55
`define ERASE_SETUP_DATA  8'h80
`define CHIP_ERASE_DATA   8'h10
`define SECTOR_ERASE_DATA 8'h30
`define RESUME_DATA       8'h30
`define SUSPEND_DATA      8'hB0
`define RESET_DATA        8'hF0
`define PREPROGRAM_FILL   8'h00
`define ERASED_FILL       8'hFF

// ************************************************************
// status byte bit positions
// ************************************************************
`define POLL_BIT          7
`define TOGGLE_BIT        6
`define ERROR_BIT         5
`define WINDOW_BIT        3

// ************************************************************
// timing
// ************************************************************
`define CLK_PERIOD_NS     100
`define WINDOW_TIME_US    100
`define WINDOW_CYCLES     ((`WINDOW_TIME_US * 1000) / `CLK_PERIOD_NS)
`define GAP_TIME_US       80
`define GAP_CYCLES        ((`GAP_TIME_US * 1000) / `CLK_PERIOD_NS)
`define PROG_TIME_US      10
`define PROG_CYCLES       ((`PROG_TIME_US * 1000) / `CLK_PERIOD_NS)
`define PULSE_TIME_US     100
`define PULSE_CYCLES      ((`PULSE_TIME_US * 1000) / `CLK_PERIOD_NS)
`define MAX_ERASE_ITER    8

// ************************************************************
// register map (byte addresses) and fields
// ************************************************************
`define CTRL_OFFSET       8'h00
`define STATUS_OFFSET     8'h04
`define IRQ_STATUS_OFFSET 8'h08
`define IRQ_MASK_OFFSET   8'h0C
`define PENDING_OFFSET    8'h10
`define CTRL_ENABLE_BIT   0
`define CTRL_RESET        1'h1
`define ERR_STATUS_BIT    16
`define BUSY_STATUS_BIT   17
`define IRQ_COUNT         3
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

//--- tb/flash_erase_sequencer_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// port checks
// ****
module flash_erase_chk #(
	parameter int MAIN_N = 8,
	parameter int BOOT_N = 4
) (
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic [MAIN_N-1:0] main_sector_selects,
	input wire logic [BOOT_N-1:0] boot_sector_selects,
	input wire logic              mem_rd,
	input wire logic [7:0]        mem_rdata,
	input wire logic              mem_rdata_valid,
	input wire logic              array_program,
	input wire logic              array_erase,
	input wire logic [7:0]        array_fill,
	input wire logic [7:0]        array_rdata,
	input wire logic              erase_busy
);
	wire logic rd_go = mem_rd && (|main_sector_selects || |boot_sector_selects);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_PROG_FILL: assert property (array_program |-> array_fill == 8'h00)
		else $error("fill not 00");
	AST_ERASE_FILL: assert property (array_erase |-> array_fill == 8'hFF)
		else $error("fill not FF");
	AST_ONE_PHASE: assert property (!(array_program && array_erase))
		else $error("both phases");
	AST_ENGINE_BUSY: assert property (array_program || array_erase |-> erase_busy)
		else $error("engine idle");
	AST_READ_ANSWER: assert property (rd_go |=> mem_rdata_valid)
		else $error("no answer");
	AST_NO_STRAY: assert property (!rd_go |=> !mem_rdata_valid)
		else $error("stray valid");
	AST_ROM_READ: assert property (rd_go && !erase_busy |=> mem_rdata == $past(array_rdata))
		else $error("rom data");
	AST_STATUS_RUN: assert property (rd_go && array_program |=> !mem_rdata[7] && mem_rdata[3])
		else $error("status bits");
	cover property ($rose(array_erase));
	cover property ($fell(erase_busy));
	cover property (rd_go && erase_busy);
endmodule : flash_erase_chk

bind flash_erase_sequencer flash_erase_chk #(.MAIN_N(MAIN_N), .BOOT_N(BOOT_N)) u_chk (.aclk, .aresetn,
	.main_sector_selects, .boot_sector_selects, .mem_rd, .mem_rdata, .mem_rdata_valid,
	.array_program, .array_erase, .array_fill, .array_rdata, .erase_busy);
`default_nettype wire

//--- tb/mcu_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// processor side of the flash bus
// ****
module mcu_bus_model (
	input  wire logic        aclk,
	output logic [11:0]      mem_addr,
	output logic [7:0]       mem_wdata,
	output logic             mem_wr,
	output logic             mem_rd,
	output logic [7:0]       main_sector_selects,
	output logic [3:0]       boot_sector_selects,
	input  wire logic [7:0]  mem_rdata,
	input  wire logic        mem_rdata_valid
);
	initial begin
		{mem_addr, mem_wdata, mem_wr, mem_rd} = '0;
		{boot_sector_selects, main_sector_selects} = '0;
	end
	// released bus shows inverse
	task automatic cyc(input logic [11:0] a, input logic [7:0] d, input logic [11:0] s, input logic w);
		@(posedge aclk);
		{mem_addr, mem_wdata, mem_wr, mem_rd} <= {a, d, w, !w};
		{boot_sector_selects, main_sector_selects} <= s;
		@(posedge aclk);
		{mem_addr, mem_wdata, mem_wr, mem_rd} <= {~a, ~d, 2'b00};
		{boot_sector_selects, main_sector_selects} <= '0;
	endtask : cyc
	task automatic rd(input logic [11:0] s, output logic [7:0] q, output logic v);
		cyc(12'h000, 8'h00, s, 1'b0);
		@(posedge aclk);
		{q, v} = {mem_rdata, mem_rdata_valid};
	endtask : rd
	task automatic cmd(input logic [11:0] s, input logic [7:0] d, input logic [11:0] a);
		cyc(12'h555, 8'hAA, s, 1'b1);
		cyc(12'hAAA, 8'h55, s, 1'b1);
		cyc(12'h555, 8'h80, s, 1'b1);
		cyc(12'h555, 8'hAA, s, 1'b1);
		cyc(12'hAAA, 8'h55, s, 1'b1);
		cyc(a, d, s, 1'b1);
	endtask : cmd
endmodule : mcu_bus_model
`default_nettype wire

//--- tb/tb_flash_erase_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// bench top
// ****
module tb_flash_erase_sequencer;
	logic        aclk, aresetn, awv, wv, bry, arv, rry, awr, bv, arr, rv, wr, rd, vld, ok, busy, irq, v, prg, ers;
	logic [1:0]  br, rr, r;
	logic [3:0]  bs;
	logic [7:0]  awa, ara, wd, rdat, ard, ms, q;
	logic [11:0] adr;
	logic [31:0] wdt, rdt, d;
	int          n_fail, n_compared, lfsr, k;
	int          pq[$];
	flash_erase_sequencer #(.GAP_CYC(20), .WINDOW_CYC(30), .PROG_CYC(3), .PULSE_CYC(5), .MAX_ITER(2)) DUT (
		.aclk, .aresetn, .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdt),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
		.s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .mem_addr(adr), .mem_wdata(wd), .mem_wr(wr),
		.mem_rd(rd), .main_sector_selects(ms), .boot_sector_selects(bs), .mem_rdata(rdat),
		.mem_rdata_valid(vld), .array_sector(), .array_program(prg), .array_erase(ers), .array_fill(),
		.array_verify_ok(ok), .array_rdata(ard), .erase_busy(busy), .irq);
	mcu_bus_model u_mcu (.aclk, .mem_addr(adr), .mem_wdata(wd), .mem_wr(wr), .mem_rd(rd),
		.main_sector_selects(ms), .boot_sector_selects(bs), .mem_rdata(rdat), .mem_rdata_valid(vld));
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	function automatic int nxt(input int x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : nxt
	// expected pending set
	function automatic int pmask();
		pmask = 0;
		foreach (pq[i]) pmask |= 1 << pq[i];
	endfunction : pmask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic test_done();
		$display("compared %0d mismatched %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : test_done
	task automatic aw(input logic [7:0] a, input logic [31:0] x);
		@(posedge aclk);
		{awa, wdt, awv, wv, bry} <= {a, x, 3'b111};
		do @(posedge aclk); while (!awr);
		{awv, wv} <= 2'b00;
		do @(posedge aclk); while (!bv);
		bry <= 1'b0;
	endtask : aw
	task automatic ar(input logic [7:0] a, output logic [31:0] x, output logic [1:0] y);
		@(posedge aclk);
		{ara, arv, rry} <= {a, 2'b11};
		do @(posedge aclk); while (!arr);
		arv <= 1'b0;
		do @(posedge aclk); while (!rv);
		{x, y} = {rdt, rr};
		rry <= 1'b0;
	endtask : ar
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] x;
		logic [1:0]  y;
		ar(a, x, y);
		chk(nm, {20'h0, x[11:0]}, e);
	endtask : rchk
	initial begin
		#(100 * 20000);
		n_fail++;
		test_done();
	end
	initial begin
		{aresetn, awv, wv, bry, arv, rry, awa, ara, wdt, ard} = '0;
		ok = 1'b1;
		lfsr = 32'h5249;
		n_fail = 0;
		n_compared = 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rchk("ctrl", 8'h00, 1);
		rchk("mask", 8'h0C, 0);
		ar(8'h40, d, r);
		chk("unmapped", {d[29:0], r}, 2'h2);
		u_mcu.cmd(12'h004, 8'h30, 12'h123);
		pq = {2};
		u_mcu.rd(12'h004, q, v);
		chk("window flag low", q & 8'hBF, 0);
		repeat (20) @(posedge aclk);
		lfsr = nxt(lfsr);
		u_mcu.cyc(lfsr[11:0], 8'h30, 12'h020, 1'b1);
		pq.push_back(5);
		repeat (20) @(posedge aclk);
		rchk("window restarted", 8'h04, erase_pkg::ST_COLLECT);
		rchk("pending", 8'h10, pmask());
		d = '0;
		for (k = 0; k < 50 && d[8] !== 1'b1; k++) ar(8'h04, d, r);
		u_mcu.cyc(12'h777, 8'hB0, 12'h020, 1'b1);
		rchk("suspended", 8'h04, erase_pkg::ST_SUSPEND);
		u_mcu.rd(12'h020, q, v);
		chk("window flag high", q[3], 1'b1);
		u_mcu.rd(12'h020, d[7:0], v);
		chk("toggle", q[6] ^ d[6], 1'b1);
		ard <= lfsr[7:0];
		u_mcu.rd(12'h001, q, v);
		chk("other sector", q, ard);
		u_mcu.cyc(12'h000, 8'h30, 12'h020, 1'b1);
		u_mcu.cyc(12'h555, 8'hAA, 12'h020, 1'b1);
		rchk("resumed", 8'h04, erase_pkg::ST_SECTOR);
		for (k = 0; k < 200 && busy !== 1'b0; k++) @(posedge aclk);
		pq.delete();
		rchk("done event", 8'h08, 1);
		rchk("pending done", 8'h10, pmask());
		chk("irq masked", irq, 1'b0);
		aw(8'h0C, 7);
		chk("irq raised", irq, 1'b1);
		aw(8'h08, 1);
		chk("irq cleared", irq, 1'b0);
		u_mcu.cyc(12'h555, 8'hAA, 12'h100, 1'b1);
		u_mcu.cyc(12'hAAA, 8'h55, 12'h100, 1'b1);
		rchk("boot unlock", 8'h04, erase_pkg::ST_UNL2);
		u_mcu.cyc(12'h555, 8'h81, 12'h100, 1'b1);
		rchk("bad byte", 8'h04, erase_pkg::ST_READ);
		rchk("abort event", 8'h08, 4);
		aw(8'h08, 4);
		u_mcu.cyc(12'h555, 8'hAA, 12'h001, 1'b1);
		repeat (25) @(posedge aclk);
		rchk("gap", 8'h04, erase_pkg::ST_READ);
		aw(8'h08, 4);
		u_mcu.cmd(12'h080, 8'h30, 12'h000);
		u_mcu.cyc(12'h000, 8'hB0, 12'h080, 1'b1);
		rchk("suspend in window", 8'h04, erase_pkg::ST_COLLECT);
		u_mcu.cyc(12'h000, 8'h55, 12'h080, 1'b1);
		rchk("window abort", 8'h04, erase_pkg::ST_READ);
		aw(8'h08, 4);
		ok <= 1'b0;
		u_mcu.cmd(12'h010, 8'h10, 12'h555);
		u_mcu.cmd(12'h010, 8'h30, 12'h000);
		rchk("bulk ignores", 8'h04, erase_pkg::ST_BULK);
		d = '0;
		for (k = 0; k < 200 && d[16] !== 1'b1; k++) ar(8'h04, d, r);
		u_mcu.rd(12'h010, q, v);
		chk("error flag", q[5], 1'b1);
		rchk("error event", 8'h08, 2);
		u_mcu.cyc(12'h000, 8'hF0, 12'h010, 1'b1);
		rchk("reset command", 8'h04, erase_pkg::ST_READ);
		chk("engine off", {prg, ers}, 0);
		test_done();
	end
endmodule : tb_flash_erase_sequencer
`default_nettype wire
